/* File: core/vic_regs.vh */
/*
  Register map, field layout, reset values and vector constants of the
  vectored interrupt controller.
  Assumes inclusion by bare name from the core/ design files.
*/
// Functional notes
// - Maskable requests are serviced only while the global mask bit is clear.
// - After reset all interrupts are disabled and the global mask is set.
// - Core finishes instruction, stacks context, sets mask, loads PC from vector.
// - Handler return restores context, clearing the global mask bit.
// - Fixed priority: reset, trap, then vectors 0 to 13 ascending.
// - Two-byte vectors descend from FFFEh; vectors 0, 6, 12, 13 unused.
// - Vector 1 time base or clock guard; 2-5 pin groups; 7-11 peripherals.
// - Any interrupt request wakes the processor from WAIT.
// - Only reset, pin groups and vector 1 wake from halt states.
// - Vector 1 wakes from active-halt only; pin groups wake both halts.
// - Software trap is taken regardless of the global mask bit.
// - Edge-triggered pin requests are latched, cleared on entering their routine.
// - Software selects trigger sensitivity of each pin group.
// - Enabled pins of one group are NANDed before edge or level detection.
// - Peripheral flag requests only when enabled and mask clear, else pending.
// - The clearing sequence discards the pending latch, even if not enabled.
// - Clock guard request raised only when enabled and activation detected.
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define VIC_CTRL_OFS    12'h000
`define VIC_SENS_OFS    12'h004
`define VIC_PINEN_OFS   12'h008
`define VIC_SRCEN_OFS   12'h00c
`define VIC_PEND_OFS    12'h010
`define VIC_STAT_OFS    12'h014

// ****************************************
// Reset values
// ****************************************
`define VIC_MASK_RST    1'b1
`define VIC_SENS_RST    8'h00
`define VIC_PINEN_RST   32'h00000000
`define VIC_SRCEN_RST   7'h00

// ****************************************
// Sensitivity codes, two bits per group
// ****************************************
`define VIC_SENS_LOW    2'h0
`define VIC_SENS_RISE   2'h1
`define VIC_SENS_FALL   2'h2
`define VIC_SENS_BOTH   2'h3

// ****************************************
// Vector addresses
// ****************************************
`define VIC_RESET_VEC   16'hfffe
`define VIC_TRAP_VEC    16'hfffc
`define VIC_VEC0_ADDR   16'hfffa

`endif

/* File: core/vic_top.v */
/*
  Vectored interrupt controller: pin group detection, peripheral pending
  latches, fixed priority, vector hand-over and wake-up, with an APB slave.
  Assumes all core and peripheral strobes run on pclk; pins are asynchronous.
*/
`timescale 1ns/1ps
`include "vic_regs.vh"

module vic_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [31:0] ext_pins,
  input  wire        tb_evt,
  input  wire        guard_evt,
  input  wire [4:0]  periph_evt,
  input  wire [4:0]  periph_clr,
  input  wire        core_boundary,
  input  wire        core_trap,
  input  wire        core_ack,
  input  wire        core_handler_return_instruction,
  input  wire        core_wait,
  input  wire        core_halt,
  input  wire        core_ahalt,
  output reg         irq_req_r,
  output reg  [15:0] vec_addr_r,
  output reg  [3:0]  vec_num_r,
  output reg         trap_sel_r,
  output reg         gmask_r,
  output reg         wake_r
);

  // ****************************************
  // Registers and nets
  // ****************************************
  reg  [31:0] pin_s1_r;
  reg  [31:0] pin_s2_r;
  reg  [7:0]  sens_r;
  reg  [31:0] pin_en_r;
  reg  [6:0]  src_en_r;
  reg  [6:0]  pend_r;
  reg  [3:0]  grp_prev_r;
  reg  [3:0]  ext_lat_r;
  reg         trap_pend_r;
  reg  [31:0] rd_data;
  reg         hit;
  wire [3:0]  grp_lvl;
  wire [3:0]  ext_req;
  wire [6:0]  src_set;
  wire [6:0]  src_req;
  wire [13:0] req;
  wire        vec1_req;
  wire        any_mask;
  wire [3:0]  pick;
  wire        acc;
  wire        wr_en;
  wire        entry;

  assign acc   = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite;
  assign entry = core_ack & irq_req_r;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 32'h00000000;
      pin_s2_r <= 32'h00000000;
    end else begin
      pin_s1_r <= ext_pins;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ****************************************
  // Pin groups, vectors 2 to 5
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : grp
      wire [7:0] p   = pin_s2_r[g*8 +: 8];
      wire [7:0] en  = pin_en_r[g*8 +: 8];
      wire [1:0] sm  = sens_r[g*2 +: 2];
      wire       on  = |en;
      wire       rise = grp_lvl[g] & ~grp_prev_r[g];
      wire       fall = ~grp_lvl[g] & grp_prev_r[g];
      wire       edg;
      // Unused pins forced high so only enabled pins reach the NAND
      assign grp_lvl[g] = on & ~&(p | ~en);
      assign edg = ((sm == `VIC_SENS_RISE) & rise) |
                   ((sm == `VIC_SENS_FALL) & fall) |
                   ((sm == `VIC_SENS_BOTH) & (rise | fall));
      assign ext_req[g] = (sm == `VIC_SENS_LOW) ? (on & ~grp_lvl[g]) : ext_lat_r[g];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          grp_prev_r[g] <= 1'b0;
          ext_lat_r[g]  <= 1'b0;
        end else begin
          grp_prev_r[g] <= grp_lvl[g];
          // New edge beats the clear on entry
          if (edg)
            ext_lat_r[g] <= 1'b1;
          else if (entry & ~trap_sel_r & (vec_num_r == g + 2))
            ext_lat_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // Peripheral pending latches
  // ****************************************
  // Bit 0 time base, bit 1 clock guard, bits 2 to 6 vectors 7 to 11
  assign src_set = {periph_evt, guard_evt & src_en_r[1], tb_evt};

  genvar i;
  generate
    for (i = 0; i < 7; i = i + 1) begin : src
      wire sw_clr = wr_en & (paddr == `VIC_PEND_OFS) & ~pwdata[i];
      wire hw_clr = (i >= 2) ? periph_clr[(i >= 2) ? i - 2 : 0] : 1'b0;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          pend_r[i] <= 1'b0;
        else if (src_set[i])
          pend_r[i] <= 1'b1;
        else if (sw_clr | hw_clr)
          pend_r[i] <= 1'b0;
      end
      assign src_req[i] = pend_r[i] & src_en_r[i];
    end
  endgenerate

  assign vec1_req = src_req[0] | src_req[1];
  // Unused vectors 0, 6, 12 and 13 are tied off
  assign req = {2'b00, src_req[6:2], 1'b0, ext_req, vec1_req, 1'b0};
  assign any_mask = (|req) & ~gmask_r;

  // ****************************************
  // Priority
  // ****************************************
  function [3:0] vic_pick;
    input [13:0] r;
    integer k;
    begin
      vic_pick = 4'h0;
      for (k = 13; k >= 0; k = k - 1) begin
        if (r[k])
          vic_pick = k[3:0];
      end
    end
  endfunction

  assign pick = vic_pick(req);

  // ****************************************
  // Vector hand-over to the core
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_r  <= 1'b0;
      vec_addr_r <= `VIC_RESET_VEC;
      vec_num_r  <= 4'h0;
      trap_sel_r <= 1'b0;
    end else if (entry) begin
      irq_req_r  <= 1'b0;
    end else if (core_boundary & ~irq_req_r) begin
      if (trap_pend_r) begin
        // Trap ignores the mask and outranks every vector
        irq_req_r  <= 1'b1;
        trap_sel_r <= 1'b1;
        vec_num_r  <= 4'h0;
        vec_addr_r <= `VIC_TRAP_VEC;
      end else if (any_mask) begin
        irq_req_r  <= 1'b1;
        trap_sel_r <= 1'b0;
        vec_num_r  <= pick;
        vec_addr_r <= `VIC_VEC0_ADDR - {11'h000, pick, 1'b0};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      trap_pend_r <= 1'b0;
    else if (core_trap)
      trap_pend_r <= 1'b1;
    else if (entry & trap_sel_r)
      trap_pend_r <= 1'b0;
  end

  // ****************************************
  // Global mask bit
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gmask_r <= `VIC_MASK_RST;
    else if (entry)
      gmask_r <= 1'b1;
    else if (core_handler_return_instruction)
      gmask_r <= 1'b0;
    else if (wr_en & (paddr == `VIC_CTRL_OFS))
      gmask_r <= pwdata[0];
  end

  // ****************************************
  // Wake-up
  // ****************************************
  // Wake ignores the mask: the core clears it on sleep entry anyway
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wake_r <= 1'b0;
    else
      wake_r <= (core_wait & ((|req) | trap_pend_r)) |
                (core_halt & (|ext_req)) |
                (core_ahalt & ((|ext_req) | vec1_req));
  end

  // ****************************************
  // APB slave
  // ****************************************
  always @* begin
    hit     = 1'b1;
    rd_data = 32'h00000000;
    if (paddr == `VIC_CTRL_OFS)
      rd_data = {31'h00000000, gmask_r};
    else if (paddr == `VIC_SENS_OFS)
      rd_data = {24'h000000, sens_r};
    else if (paddr == `VIC_PINEN_OFS)
      rd_data = pin_en_r;
    else if (paddr == `VIC_SRCEN_OFS)
      rd_data = {25'h0000000, src_en_r};
    else if (paddr == `VIC_PEND_OFS)
      rd_data = {25'h0000000, pend_r};
    else if (paddr == `VIC_STAT_OFS)
      rd_data = {7'h00, trap_pend_r, irq_req_r, 3'h0, vec_num_r, 2'h0, req};
    else
      hit = 1'b0;
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      if (acc & ~pwrite)
        prdata <= rd_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sens_r   <= `VIC_SENS_RST;
      pin_en_r <= `VIC_PINEN_RST;
      src_en_r <= `VIC_SRCEN_RST;
    end else if (wr_en) begin
      if (paddr == `VIC_SENS_OFS)
        sens_r <= pwdata[7:0];
      else if (paddr == `VIC_PINEN_OFS)
        pin_en_r <= pwdata;
      else if (paddr == `VIC_SRCEN_OFS)
        src_en_r <= pwdata[6:0];
    end
  end

endmodule

/* File: dv/vic_chk.sv */
/* Checker for the vector port of vic_top.
   Sees only top-level ports; bound in at the foot. */
`timescale 1ns/1ps
module vic_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        core_trap,
  input wire        core_boundary,
  input wire        core_ack,
  input wire        core_handler_return_instruction,
  input wire        irq_req_r,
  input wire [15:0] vec_addr_r,
  input wire [3:0]  vec_num_r,
  input wire        trap_sel_r,
  input wire        gmask_r
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence trap_seen;
    core_trap ##1 (core_boundary && !irq_req_r);
  endsequence
  vec_hold_a: assert property (irq_req_r && !core_ack |=> irq_req_r && $stable(vec_addr_r))
    else $error("vector moved");
  ack_entry_a: assert property (irq_req_r && core_ack |=> !irq_req_r && gmask_r)
    else $error("bad entry");
  mask_gate_a: assert property ($rose(irq_req_r) && !trap_sel_r |-> !$past(gmask_r))
    else $error("taken while masked");
  trap_take_a: assert property (trap_seen |=> irq_req_r && trap_sel_r)
    else $error("trap not taken");
  trap_addr_a: assert property (irq_req_r && trap_sel_r |-> vec_addr_r == 16'hfffc)
    else $error("bad trap vector");
  vec_addr_a: assert property (irq_req_r && !trap_sel_r |->
    vec_addr_r == 16'hfffa - {11'h0, vec_num_r, 1'b0})
    else $error("bad vector");
  // Trap presents number 0 too, so only maskable vectors are screened
  vec_used_a: assert property (irq_req_r && !trap_sel_r |->
    !(vec_num_r inside {4'h0, 4'h6, 4'hc, 4'hd}))
    else $error("unused vector");
  handler_return_instruction_clr_a: assert property (core_handler_return_instruction && !(core_ack && irq_req_r) |=> !gmask_r)
    else $error("mask kept");
endmodule
bind vic_top vic_chk chk_i (.pclk(pclk), .presetn(presetn), .core_trap(core_trap),
  .core_boundary(core_boundary), .core_ack(core_ack), .core_handler_return_instruction(core_handler_return_instruction),
  .irq_req_r(irq_req_r), .vec_addr_r(vec_addr_r), .vec_num_r(vec_num_r),
  .trap_sel_r(trap_sel_r), .gmask_r(gmask_r));

/* File: dv/vic_core_mdl.sv */
/* Core model: instruction boundaries and routine entry.
   Assumes vic_top samples strobes on the pclk rising edge. */
`timescale 1ns/1ps
module vic_core_mdl (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       irq_req_r,
  input  wire [3:0] ack_dly,
  output reg        core_boundary,
  output reg        core_ack
);
  reg [3:0] cnt_r;
  // Entry may lag, to prove the vector holds while the core stacks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_boundary <= 1'b0;
      core_ack <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      core_boundary <= !core_boundary && !irq_req_r;
      core_ack <= irq_req_r && !core_ack && cnt_r == ack_dly;
      cnt_r <= (irq_req_r && !core_ack) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule

/* File: dv/testbench.sv */
/* Bench for vic_top: APB tasks, event pulses, core model.
   Assumes the APB slave answers on its own; waits are bounded. */
`timescale 1ns/1ps
`include "vic_regs.vh"
module testbench;
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         tb_evt = 1'b0, guard_evt = 1'b0, core_trap = 1'b0, core_handler_return_instruction = 1'b0;
  reg         core_wait = 1'b0, core_halt = 1'b0, core_ahalt = 1'b0, err;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, ext_pins = 32'hffffffff, rd;
  reg  [4:0]  periph_evt = 5'h00, periph_clr = 5'h00;
  reg  [3:0]  ack_dly = 4'h0;
  wire [31:0] prdata;
  wire [15:0] vec_addr_r;
  wire [3:0]  vec_num_r;
  wire        pready, pslverr, core_boundary, core_ack, irq_req_r, trap_sel_r, gmask_r, wake_r;
  integer     failures = 0, checks = 0, i;
  always #5 pclk = ~pclk;
  vic_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_pins(ext_pins), .tb_evt(tb_evt), .guard_evt(guard_evt),
    .periph_evt(periph_evt), .periph_clr(periph_clr), .core_boundary(core_boundary),
    .core_trap(core_trap), .core_ack(core_ack), .core_handler_return_instruction(core_handler_return_instruction),
    .core_wait(core_wait), .core_halt(core_halt), .core_ahalt(core_ahalt),
    .irq_req_r(irq_req_r), .vec_addr_r(vec_addr_r), .vec_num_r(vec_num_r),
    .trap_sel_r(trap_sel_r), .gmask_r(gmask_r), .wake_r(wake_r));
  vic_core_mdl core (.pclk(pclk), .presetn(presetn), .irq_req_r(irq_req_r),
    .ack_dly(ack_dly), .core_boundary(core_boundary), .core_ack(core_ack));
  // ****************
  // Tasks
  // ****************
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge pclk) begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
      end
      @(posedge pclk) penable <= 1'b1;
      // Request stands until pready is sampled high at a rising edge
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (pready !== 1'b1)
        failures = failures + 1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Waits for a vector, lets the core enter, clears the source, returns
  task serve(input [15:0] va, input [11:0] ca, input [31:0] cd);
    integer n;
    reg [15:0] vd;
    begin
      n = 0;
      vd = (16'hfffa - va) >> 1;
      while (irq_req_r !== 1'b1 && n < 60) begin
        @(negedge pclk);
        n = n + 1;
      end
      chk({31'h0, irq_req_r}, 32'h1);
      chk({16'h0, vec_addr_r}, {16'h0, va});
      if (va == `VIC_TRAP_VEC)
        chk({31'h0, trap_sel_r}, 32'h1);
      else
        chk({27'h0, trap_sel_r, vec_num_r}, {16'h0, vd});
      while (irq_req_r !== 1'b0 && n < 90) begin
        @(negedge pclk);
        n = n + 1;
      end
      chk({31'h0, irq_req_r}, 32'h0);
      chk({31'h0, gmask_r}, 32'h1);
      // Peripheral flags survive entry (pin latches and trap clear on it); the handler must clear its own source
      apb(1'b1, ca, cd);
      @(posedge pclk) core_handler_return_instruction <= 1'b1;
      @(posedge pclk) core_handler_return_instruction <= 1'b0;
      @(negedge pclk) chk({31'h0, gmask_r}, 32'h0);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #100000;
    failures = failures + 1;
    give_verdict;
  end
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({irq_req_r, vec_addr_r, gmask_r}, {15'h0, 16'hfffe, 1'b1});
    apb(1'b0, `VIC_CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h018, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("end reset");
    @(posedge pclk) begin
      ack_dly <= 4'h6;
      core_trap <= 1'b1;
    end
    @(posedge pclk) core_trap <= 1'b0;
    serve(16'hfffc, `VIC_PEND_OFS, 32'hffffffff);
    $display("end trap");
    @(posedge pclk) periph_evt <= 5'h1f;
    @(posedge pclk) periph_evt <= 5'h00;
    apb(1'b0, `VIC_PEND_OFS, 32'h0);
    chk({rd[30:0], irq_req_r}, 32'hf8);
    @(posedge pclk) periph_clr <= 5'h01;
    @(posedge pclk) periph_clr <= 5'h00;
    apb(1'b0, `VIC_PEND_OFS, 32'h0);
    chk(rd, 32'h78);
    apb(1'b1, `VIC_PEND_OFS, 32'h40);
    @(posedge pclk) guard_evt <= 1'b1;
    @(posedge pclk) guard_evt <= 1'b0;
    apb(1'b0, `VIC_PEND_OFS, 32'h0);
    chk(rd, 32'h40);
    apb(1'b1, `VIC_PEND_OFS, 32'h0);
    apb(1'b1, `VIC_SRCEN_OFS, 32'h7f);
    $display("end pending");
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge pclk) periph_evt <= 5'h01 << i;
      @(posedge pclk) periph_evt <= 5'h00;
      serve(16'hffec - 16'h2 * i[15:0], `VIC_PEND_OFS, ~(32'h4 << i));
    end
    @(posedge pclk) begin
      tb_evt <= 1'b1;
      periph_evt <= 5'h10;
    end
    @(posedge pclk) begin
      tb_evt <= 1'b0;
      periph_evt <= 5'h00;
    end
    serve(16'hfff8, `VIC_PEND_OFS, 32'hfffffffe);
    serve(16'hffe4, `VIC_PEND_OFS, 32'hffffffbf);
    @(posedge pclk) guard_evt <= 1'b1;
    @(posedge pclk) guard_evt <= 1'b0;
    serve(16'hfff8, `VIC_PEND_OFS, 32'hfffffffd);
    $display("end vectors");
    apb(1'b1, `VIC_CTRL_OFS, 32'h1);
    @(posedge pclk) periph_evt <= 5'h01;
    @(posedge pclk) begin
      periph_evt <= 5'h00;
      core_halt <= 1'b1;
    end
    repeat (3) @(negedge pclk);
    chk({31'h0, wake_r}, 32'h0);
    @(posedge pclk) core_wait <= 1'b1;
    repeat (3) @(negedge pclk);
    chk({31'h0, wake_r}, 32'h1);
    @(posedge pclk) begin
      core_wait <= 1'b0;
      tb_evt <= 1'b1;
    end
    @(posedge pclk) tb_evt <= 1'b0;
    repeat (3) @(negedge pclk);
    chk({31'h0, wake_r}, 32'h0);
    @(posedge pclk) core_ahalt <= 1'b1;
    repeat (3) @(negedge pclk);
    chk({31'h0, wake_r}, 32'h1);
    @(posedge pclk) begin
      core_ahalt <= 1'b0;
      core_halt <= 1'b0;
    end
    chk({31'h0, irq_req_r}, 32'h0);
    // Requests latched while masked are taken once the mask clears
    apb(1'b1, `VIC_CTRL_OFS, 32'h0);
    serve(16'hfff8, `VIC_PEND_OFS, 32'hfffffffe);
    serve(16'hffec, `VIC_PEND_OFS, 32'hfffffffb);
    $display("end wake");
    apb(1'b1, `VIC_SENS_OFS, 32'h1);
    apb(1'b1, `VIC_PINEN_OFS, 32'h3);
    @(posedge pclk) ext_pins[0] <= 1'b0;
    serve(16'hfff6, `VIC_PEND_OFS, 32'hffffffff);
    @(posedge pclk) ext_pins[1] <= 1'b0;
    repeat (6) @(negedge pclk);
    chk({31'h0, irq_req_r}, 32'h0);
    apb(1'b1, `VIC_SENS_OFS, 32'h2);
    @(posedge pclk) ext_pins <= 32'hffffffff;
    serve(16'hfff6, `VIC_PEND_OFS, 32'hffffffff);
    // Level mode is not latched: the handler drops the pin enables
    apb(1'b1, `VIC_SENS_OFS, 32'h0);
    serve(16'hfff6, `VIC_PINEN_OFS, 32'h0);
    apb(1'b1, `VIC_SENS_OFS, 32'h3);
    apb(1'b1, `VIC_PINEN_OFS, 32'h3);
    @(posedge pclk) ext_pins[0] <= 1'b0;
    serve(16'hfff6, `VIC_PEND_OFS, 32'hffffffff);
    @(posedge pclk) ext_pins[0] <= 1'b1;
    serve(16'hfff6, `VIC_PEND_OFS, 32'hffffffff);
    $display("end pins");
    give_verdict;
  end
endmodule
